// [design/twmc_pkg.sv]
// package of constants for the two-timer waveform mode control block
// assumes an axi4-lite master with 32-bit data and aligned word accesses
package twmc_pkg;
	// ************************************************************
	// register map, one block of words per timer
	// ************************************************************
	localparam int          ADDR_W       = 8;
	localparam int          NUM_TIMERS   = 2;
	localparam logic [7:0]  TIMER_STRIDE = 8'h20;
	localparam logic [4:0]  OFS_CTL_A    = 5'h00;
	localparam logic [4:0]  OFS_CTL_B    = 5'h04;
	localparam logic [4:0]  OFS_CMP_A    = 5'h08;
	localparam logic [4:0]  OFS_CMP_B    = 5'h0C;
	localparam logic [4:0]  OFS_CAPTURE  = 5'h10;
	localparam logic [4:0]  OFS_COUNTER  = 5'h14;
	localparam logic [4:0]  OFS_STATUS   = 5'h18;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int          MODE_A_HI    = 7;
	localparam int          MODE_A_LO    = 6;
	localparam int          MODE_B_HI    = 5;
	localparam int          MODE_B_LO    = 4;
	localparam int          FORCE_A_BIT  = 3;
	localparam int          FORCE_B_BIT  = 2;
	localparam int          WGM_LO_HI    = 1;
	localparam int          WGM_LO_LO    = 0;
	localparam int          WGM_HI_HI    = 4;
	localparam int          WGM_HI_LO    = 3;
	localparam int          OVF_BIT      = 0;
	localparam int          MATCH_A_BIT  = 1;
	localparam int          MATCH_B_BIT  = 2;
	// ************************************************************
	// reset values and counter limits
	// ************************************************************
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	localparam logic [15:0] WORD_RESET   = 16'h0000;
	localparam logic [15:0] BOTTOM       = 16'h0000;
	localparam logic [15:0] MAX_VAL      = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT     = 16'h00FF;
	localparam logic [15:0] TOP_9BIT     = 16'h01FF;
	localparam logic [15:0] TOP_10BIT    = 16'h03FF;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// ************************************************************
	// waveform mode codes and output mode codes
	// ************************************************************
	localparam logic [3:0]  WGM_PFC_OCRA = 4'h9;
	localparam logic [3:0]  WGM_FAST_ICR = 4'hE;
	localparam logic [3:0]  WGM_FAST_OCR = 4'hF;
	localparam logic [1:0]  OM_OFF       = 2'h0;
	localparam logic [1:0]  OM_TOGGLE    = 2'h1;
	localparam logic [1:0]  OM_CLEAR     = 2'h2;
	localparam logic [1:0]  OM_SET       = 2'h3;
	typedef enum logic [1:0] {
		TWMC_NORMAL,
		TWMC_CTC,
		TWMC_FAST,
		TWMC_DUAL
	} twmc_class_t;
endpackage

// [design/twmc_top.sv]
// two 16-bit timers with waveform mode decode, compare outputs and force strobes
// assumes an axi4-lite master on aclk and port logic outside that muxes the pins
//
// Functional notes
// - nonzero output mode field hands the pin from the port to the waveform, except 01 in pwm modes where that channel does not toggle.
// - non-pwm modes: 00 off, 01 toggle, 10 low, 11 high on match.
// - fast pwm: 10 clears on match sets at top; 11 the reverse.
// - fast pwm 01 toggles channel a only in mode 15; otherwise off.
// - fast pwm, compare equal top with upper bit set: only top action.
// - dual slope: 10 clears on up-match, sets on down-match; 11 opposite.
// - dual slope 01 toggles channel a only in mode 9.
// - force strobes act only in non-pwm modes.
// - force strobe makes an immediate match using the output mode written with it.
// - force sets no flag and never clears the counter.
// - force bits are write-only strobes and read as zero.
// - mode low bits at control a 1:0, high bits in control b.
// - modes 1,2,3,10,11 phase correct; update at top, overflow at bottom.
// - modes 0,4,12 single slope; update immediately, overflow at max.
// - modes 5,6,7,14,15 fast pwm; update and overflow at top.
// - modes 8,9 phase and frequency correct; update and overflow at bottom.
// - dual slope counts bottom to top and back down to bottom.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module twmc_top (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [twmc_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [twmc_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic [twmc_pkg::NUM_TIMERS-1:0]   wave_pin_a,
	output logic [twmc_pkg::NUM_TIMERS-1:0]   wave_pin_b,
	output logic [twmc_pkg::NUM_TIMERS-1:0]   wave_sel_a,
	output logic [twmc_pkg::NUM_TIMERS-1:0]   wave_sel_b
);
	localparam int NT = twmc_pkg::NUM_TIMERS;

	// ************************************************************
	// mode decode
	// ************************************************************
	function automatic twmc_pkg::twmc_class_t wave_class(input logic [3:0] wgm);
		unique case (wgm)
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: wave_class = twmc_pkg::TWMC_DUAL;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF:             wave_class = twmc_pkg::TWMC_FAST;
			4'h4, 4'hC:                               wave_class = twmc_pkg::TWMC_CTC;
			default:                                  wave_class = twmc_pkg::TWMC_NORMAL;
		endcase
	endfunction

	function automatic logic [15:0] wave_top(input logic [3:0] wgm, input logic [15:0] cmp_a,
		input logic [15:0] cap);
		unique case (wgm)
			4'h1, 4'h5:             wave_top = twmc_pkg::TOP_8BIT;
			4'h2, 4'h6:             wave_top = twmc_pkg::TOP_9BIT;
			4'h3, 4'h7:             wave_top = twmc_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: wave_top = cmp_a;
			4'h8, 4'hA, 4'hC, 4'hE: wave_top = cap;
			default:                wave_top = twmc_pkg::MAX_VAL;
		endcase
	endfunction

	// next level of one waveform output
	function automatic logic wave_next(input logic cur, input logic [1:0] om,
		input twmc_pkg::twmc_class_t cls, input logic up, input logic match,
		input logic at_top, input logic eq_top, input logic tog_ok, input logic force_m);
		wave_next = cur;
		unique case (cls)
			twmc_pkg::TWMC_FAST: begin
				if (om == twmc_pkg::OM_TOGGLE) begin
					if (tog_ok && match) wave_next = ~cur;
				end else if (om[1]) begin
					if (at_top) wave_next = ~om[0];
					else if (match && !eq_top) wave_next = om[0];
				end
			end
			twmc_pkg::TWMC_DUAL: begin
				if (om == twmc_pkg::OM_TOGGLE) begin
					if (tog_ok && match) wave_next = ~cur;
				end else if (om[1] && match) begin
					wave_next = up ? om[0] : ~om[0];
				end
			end
			default: begin
				if (match || force_m) begin
					unique case (om)
						twmc_pkg::OM_TOGGLE: wave_next = ~cur;
						twmc_pkg::OM_CLEAR:  wave_next = 1'b0;
						twmc_pkg::OM_SET:    wave_next = 1'b1;
						default:             wave_next = cur;
					endcase
				end
			end
		endcase
	endfunction

	// ************************************************************
	// register bus
	// ************************************************************
	logic                        aw_held;
	logic                        w_held;
	logic [twmc_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0]                 w_data;
	logic [3:0]                  w_strb;
	logic                        bvalid;
	logic                        rvalid;
	logic [31:0]                 rdata;
	logic [1:0]                  bresp;
	logic [1:0]                  rresp;
	logic                        next_aw_held;
	logic                        next_w_held;
	logic [twmc_pkg::ADDR_W-1:0] next_aw_addr;
	logic [31:0]                 next_w_data;
	logic [3:0]                  next_w_strb;
	logic                        next_bvalid;
	logic                        next_rvalid;
	logic [31:0]                 next_rdata;
	logic [1:0]                  next_bresp;
	logic [1:0]                  next_rresp;
	logic                        wr_go;
	logic [31:0]                 rd_word;
	logic                        rd_hit;

	logic [7:0]  ctl_a   [NT];
	logic [7:0]  ctl_b   [NT];
	logic [15:0] cmp_buf_a [NT];
	logic [15:0] cmp_buf_b [NT];
	logic [15:0] capture [NT];
	logic [15:0] counter [NT];
	logic [2:0]  status  [NT];

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;
	assign wr_go         = aw_held && w_held && !bvalid;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b0;
		for (int t = 0; t < NT; t++) begin
			if (s_axi_araddr[7:5] == 3'(t)) begin
				rd_hit = 1'b1;
				unique case (s_axi_araddr[4:0])
					twmc_pkg::OFS_CTL_A: rd_word = {24'h00_0000,
						ctl_a[t] & 8'hF3};
					twmc_pkg::OFS_CTL_B:   rd_word = {24'h00_0000, ctl_b[t]};
					twmc_pkg::OFS_CMP_A:   rd_word = {16'h0000, cmp_buf_a[t]};
					twmc_pkg::OFS_CMP_B:   rd_word = {16'h0000, cmp_buf_b[t]};
					twmc_pkg::OFS_CAPTURE: rd_word = {16'h0000, capture[t]};
					twmc_pkg::OFS_COUNTER: rd_word = {16'h0000, counter[t]};
					twmc_pkg::OFS_STATUS:  rd_word = {29'h0000_0000, status[t]};
					default:               rd_hit = 1'b0;
				endcase
			end
		end
	end

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr[7:5] < 3'(NT) && aw_addr[4:0] <= twmc_pkg::OFS_STATUS
				&& aw_addr[1:0] == 2'h0) ? twmc_pkg::RESP_OKAY : twmc_pkg::RESP_SLVERR;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata  = rd_word;
			next_rresp  = rd_hit ? twmc_pkg::RESP_OKAY : twmc_pkg::RESP_SLVERR;
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= twmc_pkg::RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= twmc_pkg::RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ************************************************************
	// timers
	// ************************************************************
	for (genvar t = 0; t < NT; t++) begin : g_timer
		logic [3:0]            wgm;
		twmc_pkg::twmc_class_t cls;
		logic [15:0]           top;
		logic [15:0]           cmp_a;
		logic [15:0]           cmp_b;
		logic                  up;
		logic                  pin_a;
		logic                  pin_b;
		logic                  sel;
		logic [15:0]           next_cnt;
		logic [15:0]           next_cmp_a;
		logic [15:0]           next_cmp_b;
		logic                  next_up;
		logic                  next_pin_a;
		logic                  next_pin_b;
		logic [7:0]            next_ctl_a;
		logic [7:0]            next_ctl_b;
		logic [15:0]           next_buf_a;
		logic [15:0]           next_buf_b;
		logic [15:0]           next_cap;
		logic [2:0]            next_status;
		logic                  at_top;
		logic                  at_bot;
		logic                  match_a;
		logic                  match_b;
		logic                  force_a;
		logic                  force_b;
		logic                  tog_ok;
		logic                  upd;
		logic                  ovf;
		logic [1:0]            om_a;
		logic [1:0]            om_b;

		assign sel     = wr_go && aw_addr[7:5] == 3'(t);
		assign wgm     = {ctl_b[t][twmc_pkg::WGM_HI_HI:twmc_pkg::WGM_HI_LO],
			ctl_a[t][twmc_pkg::WGM_LO_HI:twmc_pkg::WGM_LO_LO]};
		assign cls     = wave_class(wgm);
		assign top     = wave_top(wgm, cmp_a, capture[t]);
		assign at_top  = counter[t] == top;
		assign at_bot  = counter[t] == twmc_pkg::BOTTOM;
		assign match_a = counter[t] == cmp_a;
		assign match_b = counter[t] == cmp_b;
		assign om_a    = ctl_a[t][twmc_pkg::MODE_A_HI:twmc_pkg::MODE_A_LO];
		assign om_b    = ctl_a[t][twmc_pkg::MODE_B_HI:twmc_pkg::MODE_B_LO];
		assign tog_ok  = (cls == twmc_pkg::TWMC_FAST) ? wgm == twmc_pkg::WGM_FAST_OCR
			: (wgm == twmc_pkg::WGM_PFC_OCRA || wgm == twmc_pkg::WGM_FAST_ICR);
		// strobes exist only for the write cycle, never stored
		assign force_a = sel && aw_addr[4:0] == twmc_pkg::OFS_CTL_A && w_strb[0]
			&& w_data[twmc_pkg::FORCE_A_BIT];
		assign force_b = sel && aw_addr[4:0] == twmc_pkg::OFS_CTL_A && w_strb[0]
			&& w_data[twmc_pkg::FORCE_B_BIT];

		always_comb begin
			next_ctl_a  = ctl_a[t];
			next_ctl_b  = ctl_b[t];
			next_buf_a  = cmp_buf_a[t];
			next_buf_b  = cmp_buf_b[t];
			next_cap    = capture[t];
			next_up     = up;
			upd         = 1'b0;
			ovf         = 1'b0;
			if (sel && aw_addr[4:0] == twmc_pkg::OFS_CTL_A && w_strb[0])
				next_ctl_a = w_data[7:0] & 8'hF3;
			if (sel && aw_addr[4:0] == twmc_pkg::OFS_CTL_B && w_strb[0])
				next_ctl_b = w_data[7:0] & 8'h18;
			for (int b = 0; b < 2; b++) begin
				if (sel && w_strb[b] && aw_addr[4:0] == twmc_pkg::OFS_CMP_A)
					next_buf_a[b*8 +: 8] = w_data[b*8 +: 8];
				if (sel && w_strb[b] && aw_addr[4:0] == twmc_pkg::OFS_CMP_B)
					next_buf_b[b*8 +: 8] = w_data[b*8 +: 8];
				if (sel && w_strb[b] && aw_addr[4:0] == twmc_pkg::OFS_CAPTURE)
					next_cap[b*8 +: 8] = w_data[b*8 +: 8];
			end
			if (cls == twmc_pkg::TWMC_DUAL) begin
				if (up && at_top) begin
					next_up  = 1'b0;
					next_cnt = counter[t] - 16'h0001;
				end else if (!up && at_bot) begin
					next_up  = 1'b1;
					next_cnt = counter[t] + 16'h0001;
					ovf      = 1'b1;
				end else begin
					next_cnt = up ? counter[t] + 16'h0001 : counter[t] - 16'h0001;
				end
				upd = (wgm[3:1] == 3'h4) ? (!up && at_bot) : (up && at_top);
			end else begin
				next_up  = 1'b1;
				next_cnt = at_top ? twmc_pkg::BOTTOM : counter[t] + 16'h0001;
				if (cls == twmc_pkg::TWMC_FAST) begin
					upd = at_top;
					ovf = at_top;
				end else begin
					upd = 1'b1;
					ovf = counter[t] == twmc_pkg::MAX_VAL;
				end
			end
			next_cmp_a  = upd ? cmp_buf_a[t] : cmp_a;
			next_cmp_b  = upd ? cmp_buf_b[t] : cmp_b;
			// forced matches only reach the non-pwm branch of wave_next
			// a forced match acts with the output mode written alongside it
			next_pin_a  = wave_next(pin_a,
				force_a ? next_ctl_a[twmc_pkg::MODE_A_HI:twmc_pkg::MODE_A_LO] : om_a,
				cls, up, match_a, at_top, cmp_a == top, tog_ok, force_a);
			next_pin_b  = wave_next(pin_b,
				force_b ? next_ctl_a[twmc_pkg::MODE_B_HI:twmc_pkg::MODE_B_LO] : om_b,
				cls, up, match_b, at_top, cmp_b == top, 1'b0, force_b);
			// set wins over a same-cycle write-one clear
			next_status = status[t];
			if (sel && aw_addr[4:0] == twmc_pkg::OFS_STATUS && w_strb[0])
				next_status = status[t] & ~w_data[2:0];
			next_status[twmc_pkg::OVF_BIT]     |= ovf;
			next_status[twmc_pkg::MATCH_A_BIT] |= match_a;
			next_status[twmc_pkg::MATCH_B_BIT] |= match_b;
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ctl_a[t]     <= twmc_pkg::CTL_RESET;
				ctl_b[t]     <= twmc_pkg::CTL_RESET;
				cmp_buf_a[t] <= twmc_pkg::WORD_RESET;
				cmp_buf_b[t] <= twmc_pkg::WORD_RESET;
				capture[t]   <= twmc_pkg::WORD_RESET;
				counter[t]   <= twmc_pkg::WORD_RESET;
				status[t]    <= 3'h0;
				cmp_a        <= twmc_pkg::WORD_RESET;
				cmp_b        <= twmc_pkg::WORD_RESET;
				up           <= 1'b1;
				pin_a        <= 1'b0;
				pin_b        <= 1'b0;
			end else begin
				ctl_a[t]     <= next_ctl_a;
				ctl_b[t]     <= next_ctl_b;
				cmp_buf_a[t] <= next_buf_a;
				cmp_buf_b[t] <= next_buf_b;
				capture[t]   <= next_cap;
				counter[t]   <= next_cnt;
				status[t]    <= next_status;
				cmp_a        <= next_cmp_a;
				cmp_b        <= next_cmp_b;
				up           <= next_up;
				pin_a        <= next_pin_a;
				pin_b        <= next_pin_b;
			end
		end

		assign wave_pin_a[t] = pin_a;
		assign wave_pin_b[t] = pin_b;
		assign wave_sel_a[t] = om_a != twmc_pkg::OM_OFF && !(om_a == twmc_pkg::OM_TOGGLE
			&& cls inside {twmc_pkg::TWMC_FAST, twmc_pkg::TWMC_DUAL} && !tog_ok);
		assign wave_sel_b[t] = om_b != twmc_pkg::OM_OFF && !(om_b == twmc_pkg::OM_TOGGLE
			&& cls inside {twmc_pkg::TWMC_FAST, twmc_pkg::TWMC_DUAL});
	end
endmodule // twmc_top

// [tb/tb.sv]
// self-checking bench for the two-timer waveform mode control block
// assumes twmc_pkg, twmc_top and twmc_chk are compiled before it
`timescale 1ns/1ps
module tb;
	typedef struct {logic rd; logic [1:0] resp; logic [31:0] data;} twmc_exp_t;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dat;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, wave_pin_a, wave_pin_b, wave_sel_a, wave_sel_b;
	twmc_exp_t   exp_q[$];
	twmc_exp_t   e;
	int          n_errors = 0;
	int          samples_checked = 0;
	localparam logic [1:0] OK = twmc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = twmc_pkg::RESP_SLVERR;
	twmc_top uut (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ************************************************************
	// checking and closing
	// ************************************************************
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic tmo(input logic got);
		if (!got) begin
			n_errors++;
			$display("ERROR %0t: bus answer timed out", $time);
			stop_test();
		end
	endtask
	always @(posedge aclk) begin
		if (aresetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
			rsp = s_axi_rvalid ? s_axi_rresp : s_axi_bresp;
			dat = s_axi_rvalid ? s_axi_rdata : 32'h0000_0000;
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("ERROR %0t: unexpected bus answer", $time);
			end else begin
				e = exp_q.pop_front();
				chk({s_axi_rvalid, rsp, dat}, {e.rd, e.resp, e.data}, "bus answer");
			end
		end
	end
	// ************************************************************
	// bus master
	// ************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic got;
		got = 1'b0;
		exp_q.push_back('{1'b0, r, 32'h0000_0000});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 64 && !got; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) got = 1'b1;
		end
		tmo(got);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic got;
		got = 1'b0;
		exp_q.push_back('{1'b1, r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 64 && !got; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) got = 1'b1;
		end
		tmo(got);
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	int md[9] = '{5, 5, 5, 5, 1, 1, 9, 15, 4};
	int om[9] = '{2, 3, 2, 3, 2, 3, 1, 1, 1};
	int cv[9] = '{64, 64, 255, 255, 64, 64, 64, 64, 64};
	int wn[9] = '{256, 256, 256, 256, 510, 510, 256, 130, 130};
	int ex[9] = '{65, 191, 256, 0, 128, 382, 128, 65, 65};
	initial begin
		logic [31:0] v;
		int hi;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		s_axi_wstrb <= 4'hF;
		void'($urandom(32'h72e8_46be));
		do_reset();
		rd(8'h20, 32'h0000_0000, OK);
		rd(8'h24, 32'h0000_0000, OK);
		rd(8'h1C, 32'h0000_0000, ERR);
		rd(8'h40, 32'h0000_0000, ERR);
		wr(8'h5C, 32'h0000_00FF, ERR);
		for (int i = 0; i < 3; i++) begin
			v = $urandom & 32'h0000_FFFF;
			wr(8'h2C, v, OK);
			rd(8'h2C, v, OK);
		end
		s_axi_wstrb <= 4'h1;
		wr(8'h2C, 32'h0000_ABCD, OK);
		s_axi_wstrb <= 4'hF;
		rd(8'h2C, {16'h0000, v[15:8], 8'hCD}, OK);
		$display("test registers done");
		// forced matches in normal mode: set, clear, toggle
		wr(8'h18, 32'h0000_0007, OK);
		for (int k = 3; k > 0; k--) begin
			v = {24'h00_0000, k[1:0], k[1:0], 4'hC};
			wr(8'h00, v, OK);
			chk(wave_pin_a[0], k != 2, "forced level a");
			chk(wave_pin_b[0], k != 2, "forced level b");
			rd(8'h00, v & 32'h0000_00F3, OK);
		end
		rd(8'h18, 32'h0000_0000, OK);
		$display("test force done");
		for (int k = 0; k < 9; k++) begin
			do_reset();
			wr(8'h08, cv[k], OK);
			wr(8'h00, {24'h00_0000, om[k][1:0], 4'h0, md[k][1:0]}, OK);
			wr(8'h04, {27'h0, md[k][3:2], 3'h0}, OK);
			repeat (600) @(posedge aclk);
			hi = 0;
			repeat (wn[k]) begin
				@(posedge aclk);
				if (wave_pin_a[0] === 1'b1) hi++;
			end
			chk(hi, ex[k], "high cycles");
			if (k == 3) begin
				wr(8'h00, 32'h0000_00C9, OK);
				chk(wave_pin_a[0], 1'b0, "force in pwm mode");
			end
			$display("test waveform %0d done", k);
		end
		stop_test();
	end
endmodule // tb
bind twmc_top twmc_chk u_chk (.*);

// [tb/twmc_chk_sva.sv]
// checker for the two-timer waveform mode control block, timer0 decode
// assumes binding to twmc_top and a master offering address and data together
`timescale 1ns/1ps
module twmc_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  wave_pin_a,
	input wire logic [1:0]  wave_pin_b,
	input wire logic [1:0]  wave_sel_a,
	input wire logic [1:0]  wave_sel_b
);
	// ************************************************************
	// shadow of the last committed write
	// ************************************************************
	logic [7:0] wr_a, next_wr_a, wr_d, next_wr_d;
	logic [1:0] hi, next_hi;
	logic       b_q;
	function automatic logic sel_exp(input logic [3:0] m, input logic [1:0] om, input logic ch_a);
		return (om != 2'h0) && (om[1] || m inside {4'h0, 4'h4, 4'hC, 4'hD}
			|| (ch_a && (m == 4'hF || m == 4'h9)));
	endfunction
	always_comb begin
		next_wr_a = wr_a;
		next_wr_d = wr_d;
		next_hi = hi;
		if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) begin
			next_wr_a = s_axi_awaddr;
			next_wr_d = s_axi_wdata[7:0];
		end
		if (s_axi_bvalid && !b_q && wr_a == 8'h04) begin
			next_hi = wr_d[4:3];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_a <= 8'h00;
			wr_d <= 8'h00;
			hi <= 2'h0;
			b_q <= 1'b0;
		end else begin
			wr_a <= next_wr_a;
			wr_d <= next_wr_d;
			hi <= next_hi;
			b_q <= s_axi_bvalid;
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	default clocking dcb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence resp_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	sequence ctl_a_done;
		s_axi_bvalid && !b_q && wr_a == 8'h00;
	endsequence
	write_resp_a: assert property (wr_taken |=> resp_late)
		else $error("write response timing wrong");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	force_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:0] == 5'h00
		|=> s_axi_rdata[3:2] == 2'h0) else $error("force bits read nonzero");
	mode_hi_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:0] == 5'h04
		|=> s_axi_rdata[31:5] == 27'h0 && s_axi_rdata[2:0] == 3'h0) else $error("mode high bits misplaced");
	sel_chan_a_a: assert property (ctl_a_done
		|-> wave_sel_a[0] == sel_exp({hi, wr_d[1:0]}, wr_d[7:6], 1'b1)) else $error("pin a takeover wrong");
	sel_chan_b_a: assert property (ctl_a_done
		|-> wave_sel_b[0] == sel_exp({hi, wr_d[1:0]}, wr_d[5:4], 1'b0)) else $error("pin b takeover wrong");
	force_pin_a: assert property (ctl_a_done ##0 ({hi, wr_d[1:0]} == 4'h0 && wr_d[3] && wr_d[7])
		|-> wave_pin_a[0] == wr_d[6]) else $error("forced level on pin a wrong");
	reset_out_a: assert property ($rose(aresetn) |-> wave_sel_a == 2'h0 && wave_pin_a == 2'h0)
		else $error("outputs not cleared by reset");
endmodule // twmc_chk
